// >>> inc/pom_pkg.sv
// constants for the pwm output mapping and external fault tristate block
package pom_pkg;
    // register offsets
    localparam logic [7:0] POM_ADDR_CMOS_SEL = 8'h03;
    localparam logic [7:0] POM_ADDR_AUX_EXTA_SEL = 8'h04;
    localparam logic [7:0] POM_ADDR_EXT_SEL = 8'h05;
    localparam logic [7:0] POM_ADDR_FRF_HIGH = 8'h06;
    localparam logic [7:0] POM_ADDR_FRF_LOW = 8'h07;
    localparam logic [7:0] POM_ADDR_FAULT_CTRL = 8'h10;
    localparam logic [7:0] POM_ADDR_STATUS = 8'h11;
    // reset values
    localparam logic [7:0] POM_RST_CMOS_SEL = 8'h08;
    localparam logic [7:0] POM_RST_AUX_EXTA_SEL = 8'hB9;
    localparam logic [7:0] POM_RST_EXT_SEL = 8'h77;
    localparam logic [7:0] POM_RST_FRF_HIGH = 8'h00;
    localparam logic [7:0] POM_RST_FRF_LOW = 8'h03;
    localparam logic [7:0] POM_RST_FAULT_CTRL = 8'h00;
    // fault control fields
    localparam int POM_BIT_FLT_TRIST_EN = 0;
    // status fields
    localparam int POM_BIT_ST_TRIST = 0;
    localparam int POM_BIT_ST_FAULT = 1;
    localparam int POM_BIT_ST_WAIT = 2;
    // recovery time unit: 41.66 us, in hundredths of ns, at 20 ns clock period
    localparam int POM_UNIT_NS_X100 = 4166000;
    localparam int POM_CLK_PERIOD_NS_X100 = 2000;
    localparam int POM_UNIT_CYC_INT = POM_UNIT_NS_X100 / POM_CLK_PERIOD_NS_X100;
    localparam logic [11:0] POM_UNIT_CYC = 12'(POM_UNIT_CYC_INT);
    localparam logic [11:0] POM_UNIT_CYC_LAST = 12'(POM_UNIT_CYC_INT - 1);
    localparam logic [7:0] POM_ZERO8 = 8'h00;
    localparam logic [11:0] POM_ZERO12 = 12'h000;
    localparam logic [11:0] POM_ONE12 = 12'h001;
    localparam logic [15:0] POM_ZERO16 = 16'h0000;
    localparam logic [15:0] POM_ONE16 = 16'h0001;
    // select field widths and positions, lsb of each field in its register
    localparam int POM_SEL_W = 3;
    localparam int POM_SPLIT_HI_W = 2;
    localparam int POM_SPLIT_LO_W = 2;
    localparam int POM_POS_CMOS1 = 5;
    localparam int POM_POS_CMOS2 = 2;
    localparam int POM_POS_CMOS3_HI = 0;
    localparam int POM_POS_CMOS3_LO = 7;
    localparam int POM_POS_AUX = 4;
    localparam int POM_POS_EXT1A = 1;
    localparam int POM_POS_EXT1B_HI = 0;
    localparam int POM_POS_EXT1B_LO = 6;
    localparam int POM_POS_EXT2A = 3;
    localparam int POM_POS_EXT2B = 0;
    // recovery state machine
    typedef enum logic [1:0] {POM_IDLE, POM_FAULT, POM_WAIT} pom_state_t;
endpackage

// >>> testbench/pom_bridge_model.sv
// external bridge stage model raising the fault line
`timescale 1ns/1ps
// ----
// fault source
// ----
module pom_bridge_model
(
    input wire logic fault_req,
    output logic ext_fault
);
    // fault follows the bench request, no filtering
    assign ext_fault = fault_req;
endmodule

// >>> testbench/pom_output_map_properties.sv
// assertions for the pwm output map block
`timescale 1ns/1ps
// ----
// checker
// ----
module pom_output_map_properties
    import pom_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] pwm_a,
    input wire logic [3:0] pwm_b,
    input wire logic ext_fault,
    input wire logic [2:0] cmos_out,
    input wire logic aux_pwm_out,
    input wire logic ext_out1a,
    input wire logic ext_out1b,
    input wire logic ext_out2a,
    input wire logic ext_out2b,
    input wire logic ext_tristate
);
    logic [63:0] sh_r;
    logic en_r;
    logic [31:0] cnt_r;
    logic [7:0] v, frf_hi, frf_lo;
    logic [2:0] e_cmos;
    logic [3:0] e_rest, slots;
    logic e_1b;
    logic [31:0] exp_len;
    // register shadows and recovery wait counter
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sh_r <= {POM_RST_FRF_LOW, POM_RST_FRF_HIGH, POM_RST_EXT_SEL,
                POM_RST_AUX_EXTA_SEL, POM_RST_CMOS_SEL, 24'h000000};
            en_r <= 1'b0;
            cnt_r <= 32'h00000000;
        end
        else
        begin
            if (reg_wr && reg_addr < 8'h08)
                sh_r[reg_addr[2:0] * 8 +: 8] <= reg_wdata;
            if (reg_wr && reg_addr == POM_ADDR_FAULT_CTRL)
                en_r <= reg_wdata[POM_BIT_FLT_TRIST_EN];
            cnt_r <= (ext_fault || !ext_tristate) ? 32'h00000000 : cnt_r + 32'h00000001;
        end
    end
    // expected slot values from the shadowed selects
    assign v = {pwm_b[3], pwm_a[3], pwm_b[2], pwm_a[2], pwm_b[1], pwm_a[1], pwm_b[0], pwm_a[0]};
    assign e_cmos = {v[{sh_r[25:24], sh_r[39]}], v[sh_r[28:26]], v[sh_r[31:29]]};
    assign e_1b = v[{sh_r[32], sh_r[47:46]}];
    assign e_rest = {v[sh_r[42:40]], v[sh_r[45:43]], v[sh_r[38:36]], v[sh_r[35:33]]};
    assign slots = {ext_out2b, ext_out2a, aux_pwm_out, ext_out1a};
    assign frf_hi = sh_r[55:48];
    assign frf_lo = sh_r[63:56];
    assign exp_len = {16'h0000, frf_hi, frf_lo} * 32'(POM_UNIT_CYC_INT) + 32'h00000001;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_enter;
        ext_fault && en_r && !ext_tristate;
    endsequence
    sequence s_release;
        ext_tristate && !ext_fault ##1 !ext_tristate;
    endsequence
    AST_CMOS_ROUTE: assert property ($past(reset_n) |-> cmos_out == $past(e_cmos))
        else $error("cmos output off its source");
    AST_EXT1B_ROUTE: assert property ($past(reset_n) |-> ext_out1b == $past(e_1b))
        else $error("ext out1b off its split select");
    AST_SLOT_ROUTE: assert property ($past(reset_n) |-> slots == $past(e_rest))
        else $error("slot output off its source");
    AST_RD_HIGH: assert property (reg_rd && reg_addr == POM_ADDR_FRF_HIGH
        |=> reg_rdata == $past(frf_hi)) else $error("factor high byte readback wrong");
    AST_RD_LOW: assert property (reg_rd && reg_addr == POM_ADDR_FRF_LOW
        |=> reg_rdata == $past(frf_lo)) else $error("factor low byte readback wrong");
    AST_FAULT_ENTER: assert property (s_enter |=> ext_tristate)
        else $error("enabled fault not tristated");
    AST_FAULT_IGNORE: assert property (ext_fault && !en_r && !ext_tristate |=> !ext_tristate)
        else $error("disabled fault tristated");
    AST_FAULT_HOLD: assert property (ext_fault && ext_tristate |=> ext_tristate)
        else $error("tristate dropped during fault");
    AST_RELEASE_TIME: assert property (s_release |-> cnt_r == exp_len)
        else $error("tristate released at wrong time");
endmodule
bind pom_output_map pom_output_map_properties u_props (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .pwm_a(pwm_a),
    .pwm_b(pwm_b),
    .ext_fault(ext_fault),
    .cmos_out(cmos_out),
    .aux_pwm_out(aux_pwm_out),
    .ext_out1a(ext_out1a),
    .ext_out1b(ext_out1b),
    .ext_out2a(ext_out2a),
    .ext_out2b(ext_out2b),
    .ext_tristate(ext_tristate)
);

// >>> testbench/tb.sv
// self-checking bench for the pwm output map block
`timescale 1ns/1ps
`define CHK(g, w) begin checked++; if ((g) !== (w)) begin num_errors++; \
    $display("[FAIL] %0t got %0h want %0h", $time, g, w); end end
// ----
// bench
// ----
module tb
    import pom_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] pwm_a = 4'h0;
    logic [3:0] pwm_b = 4'h0;
    logic fault_req = 1'b0;
    logic [7:0] reg_rdata, q, pat, outs;
    logic [2:0] cmos_out;
    logic ext_fault, aux_pwm_out, ext_out1a, ext_out1b, ext_out2a, ext_out2b, ext_tristate, t;
    logic [7:0] ra [6] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h20};
    logic [7:0] rv [6] = '{8'h08, 8'hB9, 8'h77, 8'h00, 8'h03, 8'h00};
    int num_errors = 0, checked = 0, cyc = 0, n;
    initial forever #10 clk_sys = ~clk_sys;
    pom_output_map u_dut (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .pwm_a(pwm_a),
        .pwm_b(pwm_b),
        .ext_fault(ext_fault),
        .cmos_out(cmos_out),
        .aux_pwm_out(aux_pwm_out),
        .ext_out1a(ext_out1a),
        .ext_out1b(ext_out1b),
        .ext_out2a(ext_out2a),
        .ext_out2b(ext_out2b),
        .ext_tristate(ext_tristate)
    );
    pom_bridge_model u_bridge (.fault_req(fault_req), .ext_fault(ext_fault));
    assign outs = {ext_out2b, ext_out2a, ext_out1b, ext_out1a, aux_pwm_out, cmos_out};
    // cycle ceiling against hangs
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            conclude();
        end
    end
    // one register cycle, read data taken in the cycle after
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        q = reg_rdata;
        @(posedge clk_sys);
    endtask
    // fault pulse, then cycles until the tristate drops
    task automatic pulse();
        fault_req <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 t = ext_tristate;
        @(posedge clk_sys);
        fault_req <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
            #1;
        end
        while (ext_tristate !== 1'b0 && n < 9000);
        @(posedge clk_sys);
    endtask
    task automatic conclude();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        for (int i = 0; i < 6; i++)
        begin
            acc(1'b0, ra[i], 8'h00);
            `CHK(q, rv[i])
        end
        acc(1'b1, 8'h06, 8'hA5);
        acc(1'b0, 8'h06, 8'h00);
        `CHK(q, 8'hA5)
        $display("test registers done");
        for (int s = 0; s < 8; s++)
        begin
            acc(1'b1, 8'h03, {s[2:0], s[2:0], s[2:1]});
            acc(1'b1, 8'h04, {s[0], s[2:0], s[2:0], s[2]});
            acc(1'b1, 8'h05, {s[1:0], s[2:0], s[2:0]});
            pat = s[0] ? {4'h1 << s[2:1], 4'h0} : {4'h0, 4'h1 << s[2:1]};
            for (int k = 0; k < 2; k++)
            begin
                {pwm_b, pwm_a} <= k ? ~pat : pat;
                @(posedge clk_sys);
                @(negedge clk_sys);
                `CHK(outs, k ? 8'h00 : 8'hFF)
                @(posedge clk_sys);
            end
        end
        $display("test routing done");
        acc(1'b1, 8'h06, 8'h00);
        pulse();
        `CHK(t, 1'b0)
        acc(1'b1, 8'h10, 8'h01);
        acc(1'b0, 8'h10, 8'h00);
        `CHK(q, 8'h01)
        for (int f = 1; f >= 0; f--)
        begin
            acc(1'b1, 8'h07, 8'(f));
            pulse();
            `CHK(t, 1'b1)
            `CHK(n, 1 + f * 2083)
        end
        $display("test fault recovery done");
        conclude();
    end
endmodule

// >>> verilog/pom_output_map.sv
// pwm source to output slot routing with external bridge fault tristate
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
// How it works
// - select upper bits channel, lowest bit phase
// - ext out1b select split across two registers
// - hold tristate for programmed time after fault
// - duration is factor times 41.66 us
// - factor high byte at 0x06, reset zero
// - fault tristates only when enable bit set
// - factor low byte at 0x07, reset 0x03
module pom_output_map
    import pom_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [3:0] pwm_a,
    input wire logic [3:0] pwm_b,
    input wire logic ext_fault,
    output logic [2:0] cmos_out,
    output logic aux_pwm_out,
    output logic ext_out1a,
    output logic ext_out1b,
    output logic ext_out2a,
    output logic ext_out2b,
    output logic ext_tristate
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // map: 0x03 to 0x05 selects, 0x06 and 0x07 factor, 0x10 control, 0x11 status
    logic [7:0] cmos_sel_r;
    logic [7:0] cmos_sel_nxt;
    logic [7:0] aux_exta_sel_r;
    logic [7:0] aux_exta_sel_nxt;
    logic [7:0] ext_sel_r;
    logic [7:0] ext_sel_nxt;
    logic [7:0] frf_high_r;
    logic [7:0] frf_high_nxt;
    logic [7:0] frf_low_r;
    logic [7:0] frf_low_nxt;
    logic [7:0] fault_ctrl_r;
    logic [7:0] fault_ctrl_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [7:0] status;

    // register write and read decode
    // unmapped writes are dropped, the status word has no write path
    always_comb
    begin
        cmos_sel_nxt = cmos_sel_r;
        aux_exta_sel_nxt = aux_exta_sel_r;
        ext_sel_nxt = ext_sel_r;
        frf_high_nxt = frf_high_r;
        frf_low_nxt = frf_low_r;
        fault_ctrl_nxt = fault_ctrl_r;
        rdata_nxt = POM_ZERO8;
        if (reg_wr)
        begin
            unique case (reg_addr)
                POM_ADDR_CMOS_SEL: cmos_sel_nxt = reg_wdata;
                POM_ADDR_AUX_EXTA_SEL: aux_exta_sel_nxt = reg_wdata;
                POM_ADDR_EXT_SEL: ext_sel_nxt = reg_wdata;
                POM_ADDR_FRF_HIGH: frf_high_nxt = reg_wdata;
                POM_ADDR_FRF_LOW: frf_low_nxt = reg_wdata;
                POM_ADDR_FAULT_CTRL: fault_ctrl_nxt = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                POM_ADDR_CMOS_SEL: rdata_nxt = cmos_sel_r;
                POM_ADDR_AUX_EXTA_SEL: rdata_nxt = aux_exta_sel_r;
                POM_ADDR_EXT_SEL: rdata_nxt = ext_sel_r;
                POM_ADDR_FRF_HIGH: rdata_nxt = frf_high_r;
                POM_ADDR_FRF_LOW: rdata_nxt = frf_low_r;
                POM_ADDR_FAULT_CTRL: rdata_nxt = fault_ctrl_r;
                POM_ADDR_STATUS: rdata_nxt = status;
                default: rdata_nxt = POM_ZERO8; // unmapped reads zero
            endcase
        end
    end

    // register file, reset to the power-on defaults
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmos_sel_r <= POM_RST_CMOS_SEL;
            aux_exta_sel_r <= POM_RST_AUX_EXTA_SEL;
            ext_sel_r <= POM_RST_EXT_SEL;
            frf_high_r <= POM_RST_FRF_HIGH;
            frf_low_r <= POM_RST_FRF_LOW;
            fault_ctrl_r <= POM_RST_FAULT_CTRL;
            rdata_r <= POM_ZERO8;
        end
        else
        begin
            cmos_sel_r <= cmos_sel_nxt;
            aux_exta_sel_r <= aux_exta_sel_nxt;
            ext_sel_r <= ext_sel_nxt;
            frf_high_r <= frf_high_nxt;
            frf_low_r <= frf_low_nxt;
            fault_ctrl_r <= fault_ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // read data stands one cycle, then returns to zero
    assign reg_rdata = rdata_r;

    // ----------------------------------------
    // output routing
    // ----------------------------------------
    logic [2:0] cmos_out1_select;
    logic [2:0] cmos_out2_select;
    logic [2:0] cmos_out3_select;
    logic [2:0] aux_pwm_select;
    logic [2:0] ext_out1a_select;
    logic [2:0] ext_out1b_select;
    logic [2:0] ext_out2a_select;
    logic [2:0] ext_out2b_select;
    logic [7:0] src;
    logic [7:0] route_nxt;
    logic [7:0] route_r;

    // select fields, some split across registers
    // a split select is written in two steps; between the two writes the
    // slot follows a mixed index, so software should write both back to back
    assign cmos_out1_select = cmos_sel_r[POM_POS_CMOS1 +: POM_SEL_W];
    assign cmos_out2_select = cmos_sel_r[POM_POS_CMOS2 +: POM_SEL_W];
    assign cmos_out3_select = {cmos_sel_r[POM_POS_CMOS3_HI +: POM_SPLIT_HI_W],
        aux_exta_sel_r[POM_POS_CMOS3_LO]};
    assign aux_pwm_select = aux_exta_sel_r[POM_POS_AUX +: POM_SEL_W];
    assign ext_out1a_select = aux_exta_sel_r[POM_POS_EXT1A +: POM_SEL_W];
    assign ext_out1b_select = {aux_exta_sel_r[POM_POS_EXT1B_HI],
        ext_sel_r[POM_POS_EXT1B_LO +: POM_SPLIT_LO_W]};
    assign ext_out2a_select = ext_sel_r[POM_POS_EXT2A +: POM_SEL_W];
    assign ext_out2b_select = ext_sel_r[POM_POS_EXT2B +: POM_SEL_W];

    // source index = channel*2 + phase
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            src[2 * i] = pwm_a[i];
            src[2 * i + 1] = pwm_b[i];
        end
    end

    // each slot indexes the source vector on its own
    // several slots may share one source, nothing arbitrates between them
    always_comb
    begin
        route_nxt[0] = src[cmos_out1_select];
        route_nxt[1] = src[cmos_out2_select];
        route_nxt[2] = src[cmos_out3_select];
        route_nxt[3] = src[aux_pwm_select];
        route_nxt[4] = src[ext_out1a_select];
        route_nxt[5] = src[ext_out1b_select];
        route_nxt[6] = src[ext_out2a_select];
        route_nxt[7] = src[ext_out2b_select];
    end

    // slot flops, cleared in reset so the bridges see a quiet level
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            route_r <= POM_ZERO8;
        else
            route_r <= route_nxt;
    end

    // slot flops onto the output pins
    assign cmos_out = route_r[2:0];
    assign aux_pwm_out = route_r[3];
    assign ext_out1a = route_r[4];
    assign ext_out1b = route_r[5];
    assign ext_out2a = route_r[6];
    assign ext_out2b = route_r[7];

    // ----------------------------------------
    // fault recovery tristate
    // ----------------------------------------
    pom_state_t state_r;
    pom_state_t state_nxt;
    logic [11:0] unit_cnt_r;
    logic [11:0] unit_cnt_nxt;
    logic [15:0] unit_left_r;
    logic [15:0] unit_left_nxt;
    logic trist_r;
    logic trist_nxt;
    logic ext_fault_tristate_enable;
    logic [15:0] ext_fault_recovery_factor;

    // enable bit and the 16-bit factor, both bytes live, no latching
    assign ext_fault_tristate_enable = fault_ctrl_r[POM_BIT_FLT_TRIST_EN];
    assign ext_fault_recovery_factor = {frf_high_r, frf_low_r};

    // fault holds tristate, then count factor units of 41.66 us
    // the factor is taken when the fault drops, so a later write only
    // affects the next recovery; the enable gates entry only, not the hold
    always_comb
    begin
        state_nxt = state_r;
        unit_cnt_nxt = unit_cnt_r;
        unit_left_nxt = unit_left_r;
        trist_nxt = trist_r;
        unique case (state_r)
            POM_IDLE:
            begin
                trist_nxt = 1'b0;
                if (ext_fault && ext_fault_tristate_enable)
                begin
                    state_nxt = POM_FAULT;
                    trist_nxt = 1'b1;
                end
            end
            POM_FAULT:
            begin
                trist_nxt = 1'b1;
                if (!ext_fault)
                begin
                    unit_cnt_nxt = POM_ZERO12;
                    unit_left_nxt = ext_fault_recovery_factor;
                    if (ext_fault_recovery_factor == POM_ZERO16)
                    begin
                        state_nxt = POM_IDLE;
                        trist_nxt = 1'b0;
                    end
                    else
                        state_nxt = POM_WAIT;
                end
            end
            POM_WAIT:
            begin
                trist_nxt = 1'b1;
                if (ext_fault)
                    state_nxt = POM_FAULT; // fault again restarts wait
                else if (unit_cnt_r == POM_UNIT_CYC_LAST)
                begin
                    unit_cnt_nxt = POM_ZERO12;
                    unit_left_nxt = unit_left_r - POM_ONE16;
                    if (unit_left_r == POM_ONE16)
                    begin
                        state_nxt = POM_IDLE;
                        trist_nxt = 1'b0;
                    end
                end
                else
                    unit_cnt_nxt = unit_cnt_r + POM_ONE12;
            end
            default:
            begin
                state_nxt = POM_IDLE; // unused state code, recover to idle
                trist_nxt = 1'b0;
            end
        endcase
    end

    // recovery state and counters
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= POM_IDLE;
            unit_cnt_r <= POM_ZERO12;
            unit_left_r <= POM_ZERO16;
            trist_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            unit_cnt_r <= unit_cnt_nxt;
            unit_left_r <= unit_left_nxt;
            trist_r <= trist_nxt;
        end
    end

    // tristate request straight from its flop
    assign ext_tristate = trist_r;

    // ----------------------------------------
    // status
    // ----------------------------------------
    // status view of the recovery logic
    // read-only: a write to its address falls in the default arm
    always_comb
    begin
        status = POM_ZERO8;
        status[POM_BIT_ST_TRIST] = trist_r;
        status[POM_BIT_ST_FAULT] = (state_r == POM_FAULT);
        status[POM_BIT_ST_WAIT] = (state_r == POM_WAIT);
    end

endmodule
